/* design/ppoc_pkg.sv */
// Package for the port power and overcurrent pin block
package ppoc_pkg;

	// Number of downstream ports served
	localparam int PPOC_NUM_PORTS = 4;

	// Overcurrent must be seen low this many cycles in a row plus one more to count
	localparam logic [2:0] PPOC_OC_FILTER = 3'h3;

	// Cycles after a port is enabled before the pin is trusted
	localparam logic [2:0] PPOC_SETTLE = 3'h4;

	// Zero and one for counters
	localparam logic [2:0] PPOC_CNT_ZERO = 3'h0;
	localparam logic [2:0] PPOC_CNT_ONE  = 3'h1;

	// Per-port pin state, Gray coded along off -> settle -> on
	typedef enum logic [1:0] {
		PPOC_OFF    = 2'h0,
		PPOC_SETTLE_ST = 2'h1,
		PPOC_ON     = 2'h3
	} ppoc_state_t;

	// Pin drive bundle for one port
	typedef struct packed {
		logic outVal;
		logic outEn;
		logic pullUpEn;
	} ppoc_pin_t;

endpackage : ppoc_pkg

/* design/ppoc_port_ctl.sv */
// One port's power pin controller: drive, sample and overcurrent latch
`timescale 1ns/10ps
module ppoc_port_ctl
	import ppoc_pkg::*;
(
	// Clock and reset
	input  wire logic      ref_clk,
	input  wire logic      reset_n,
	input  wire logic      clkEn,
	// Control
	input  wire logic      portEnable,
	input  wire logic      ocClear,
	// Pin
	input  wire logic      pinIn,
	output ppoc_pin_t      pinDrive,
	// Status
	output logic           ocActive,
	output logic           ocLatched
);

	typedef struct packed {
		logic        sync1;
		logic        sync2;
		ppoc_state_t state;
		logic [2:0]  cnt;
		logic [2:0]  lowCnt;
		ppoc_pin_t   pin;
		logic        active;
		logic        latched;
	} ppoc_port_t;

	ppoc_port_t state_reg;
	ppoc_port_t state_next;

	// Next state; the pin is only judged once settled and undriven
	always_comb begin
		state_next = state_reg;
		state_next.sync1 = pinIn;
		state_next.sync2 = state_reg.sync1;
		case (state_reg.state)
			PPOC_OFF: begin
				state_next.pin = '{outVal: 1'b0, outEn: 1'b1,
					pullUpEn: 1'b0};
				state_next.active = 1'b0;
				state_next.lowCnt = PPOC_CNT_ZERO;
				if (portEnable) begin
					state_next.state = PPOC_SETTLE_ST;
					state_next.cnt = PPOC_CNT_ZERO;
					state_next.pin = '{outVal: 1'b0, outEn: 1'b0,
						pullUpEn: 1'b1};
				end
			end
			PPOC_SETTLE_ST: begin
				// Pull-up needs time to lift the pin before sampling
				state_next.cnt = state_reg.cnt + PPOC_CNT_ONE;
				if (!portEnable) begin
					state_next.state = PPOC_OFF;
					state_next.pin.outEn = 1'b1;
					state_next.pin.pullUpEn = 1'b0;
				end else if (state_reg.cnt == PPOC_SETTLE - PPOC_CNT_ONE) begin
					state_next.state = PPOC_ON;
				end
			end
			PPOC_ON: begin
				// Pull-up alone signals power-on to the switch
				state_next.pin = '{outVal: 1'b0, outEn: 1'b0,
					pullUpEn: 1'b1};
				if (!portEnable) begin
					state_next.state = PPOC_OFF;
					state_next.pin = '{outVal: 1'b0, outEn: 1'b1,
						pullUpEn: 1'b0};
					state_next.active = 1'b0;
				end else if (!state_reg.sync2) begin
					// Low pin is overcurrent, filtered for glitches
					if (state_reg.lowCnt != PPOC_OC_FILTER)
						state_next.lowCnt = state_reg.lowCnt + PPOC_CNT_ONE;
					else
						state_next.active = 1'b1;
				end else begin
					state_next.lowCnt = PPOC_CNT_ZERO;
					state_next.active = 1'b0;
				end
			end
			default: begin
				state_next.state = PPOC_OFF;
			end
		endcase
		// Sticky flag: a new event beats a clear in the same cycle
		if (state_next.active)
			state_next.latched = 1'b1;
		else if (ocClear)
			state_next.latched = 1'b0;
	end

	// State register, frozen while the clock enable is low
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			state_reg <= '{sync1: 1'b1, sync2: 1'b1, state: PPOC_OFF,
				cnt: PPOC_CNT_ZERO, lowCnt: PPOC_CNT_ZERO,
				pin: '{outVal: 1'b0, outEn: 1'b1, pullUpEn: 1'b0},
				active: 1'b0, latched: 1'b0};
		end else if (clkEn) begin
			state_reg <= state_next;
		end
	end

	assign pinDrive  = state_reg.pin;
	assign ocActive  = state_reg.active;
	assign ocLatched = state_reg.latched;

	// Enabled and settled means the driver is off with pull-up on
	a_drv_off_on: assert property (@(posedge ref_clk) disable iff (!reset_n)
		(state_reg.state == PPOC_ON) |-> (!pinDrive.outEn && pinDrive.pullUpEn))
		else $error("driver on while port enabled");

	// Disable drives the pin low by the next cycle
	a_disable_low: assert property (@(posedge ref_clk) disable iff (!reset_n)
		(clkEn && !portEnable) |=> (pinDrive.outEn && !pinDrive.outVal))
		else $error("disabled port not driven low");

	sequence s_low_run;
		clkEn && state_reg.state == PPOC_ON && portEnable && !state_reg.sync2;
	endsequence

	// Four low samples in a row raise the overcurrent flag
	a_oc_detect: assert property (@(posedge ref_clk) disable iff (!reset_n)
		s_low_run [*4] |=> ocActive)
		else $error("overcurrent not reported");

	// Flag is never raised while the pin is driven
	a_oc_ignore: assert property (@(posedge ref_clk) disable iff (!reset_n)
		pinDrive.outEn |-> !ocActive)
		else $error("overcurrent seen on driven pin");

	// Latched flag holds until cleared
	a_latch_hold: assert property (@(posedge ref_clk) disable iff (!reset_n)
		(ocLatched && !ocClear) |=> ocLatched)
		else $error("latched flag lost");

	// Raised flag always latches
	a_latch_set: assert property (@(posedge ref_clk) disable iff (!reset_n)
		ocActive |-> ocLatched)
		else $error("active flag not latched");

endmodule : ppoc_port_ctl

/* design/ppoc_pins.sv */
// Four-port power-control pin block of the hub
//
// Overview of operation
// - Four independent power pins, one per downstream port 1 to 4.
// - Enabled port: pin is input, pull-up on, driver off.
// - Pull-up high level tells the switch to power the port.
// - Enabled port: low pin level means overcurrent on that port.
// - Disabled port: pin becomes an output driven low.
// - One pin covers both USB 2.0 and USB 3.1 halves.
`timescale 1ns/10ps
module ppoc_pins
	import ppoc_pkg::*;
(
	// Clock, reset, enable
	input  wire logic                      ref_clk,
	input  wire logic                      reset_n,
	input  wire logic                      clkEn,
	// Port control from configuration and host
	input  wire logic [PPOC_NUM_PORTS-1:0] portEnable,
	input  wire logic [PPOC_NUM_PORTS-1:0] ocClear,
	// Power-control pins
	input  wire logic [PPOC_NUM_PORTS-1:0] powerSenseIn,
	output logic      [PPOC_NUM_PORTS-1:0] powerSenseOut,
	output logic      [PPOC_NUM_PORTS-1:0] powerSenseOe,
	output logic      [PPOC_NUM_PORTS-1:0] powerSensePullUp,
	// Status to both the USB 2.0 and USB 3.1 hub halves
	output logic      [PPOC_NUM_PORTS-1:0] ocActive,
	output logic      [PPOC_NUM_PORTS-1:0] ocLatched
);

	// One independent controller per port
	genvar i;
	generate
		for (i = 0; i < PPOC_NUM_PORTS; i++) begin : g_port
			ppoc_pin_t drv;
			ppoc_port_ctl u_ctl (
				.ref_clk    (ref_clk),
				.reset_n    (reset_n),
				.clkEn      (clkEn),
				.portEnable (portEnable[i]),
				.ocClear    (ocClear[i]),
				.pinIn      (powerSenseIn[i]),
				.pinDrive   (drv),
				.ocActive   (ocActive[i]),
				.ocLatched  (ocLatched[i])
			);
			assign powerSenseOut[i]    = drv.outVal;
			assign powerSenseOe[i]     = drv.outEn;
			assign powerSensePullUp[i] = drv.pullUpEn;
		end
	endgenerate

endmodule : ppoc_pins

/* verif/ppoc_switch_model.sv */
// Model of the external port power switch and current monitor
`timescale 1ns/10ps
module ppoc_switch_model (
	// Clock, used only as a float pattern
	input  wire logic       ref_clk,
	// Fault command from the bench
	input  wire logic [3:0] faultReq,
	// Hub pin drive
	input  wire logic [3:0] pinOut,
	input  wire logic [3:0] pinOe,
	input  wire logic [3:0] pinPullUp,
	// Wire and switch state
	output logic      [3:0] pinLevel,
	output logic      [3:0] powerOn
);
	// Resolve each wire; an unpulled, undriven pin floats, so it toggles
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			if (pinOe[i]) pinLevel[i] = pinOut[i];
			else if (faultReq[i]) pinLevel[i] = 1'b0;
			else if (pinPullUp[i]) pinLevel[i] = 1'b1;
			else pinLevel[i] = ref_clk;
		end
	end
	// Switch follows the wire: high powers the port
	assign powerOn = pinLevel;
endmodule : ppoc_switch_model

/* verif/ppoc_pins_tb_top.sv */
// Self-checking bench for the port power pin block
`timescale 1ns/10ps
module ppoc_pins_tb_top;
	import ppoc_pkg::*;
	logic        ref_clk    = 1'b0;
	logic        reset_n    = 1'b0;
	logic        clkEn      = 1'b1;
	logic [3:0]  portEnable = 4'h0;
	logic [3:0]  ocClear    = 4'h0;
	logic [3:0]  faultReq   = 4'h0;
	logic [3:0]  pinLvl, pOut, pOe, pPu, ocAct, ocLat, pwrOn;
	int          fails = 0, testsRun = 0, cyc = 0;
	// Rows: enable, fault, expected oe, pull-up, ocActive, power
	logic [23:0] rows [4] = '{24'hF0_0F0F, 24'hF5_0F5A,
		24'h3F_C330, 24'h00_F000};
	always #4 ref_clk = ~ref_clk;
	ppoc_pins dut_u (.ref_clk(ref_clk), .reset_n(reset_n), .clkEn(clkEn),
		.portEnable(portEnable), .ocClear(ocClear), .powerSenseIn(pinLvl),
		.powerSenseOut(pOut), .powerSenseOe(pOe), .powerSensePullUp(pPu),
		.ocActive(ocAct), .ocLatched(ocLat));
	ppoc_switch_model model_u (.ref_clk(ref_clk), .faultReq(faultReq),
		.pinOut(pOut), .pinOe(pOe), .pinPullUp(pPu), .pinLevel(pinLvl),
		.powerOn(pwrOn));
	task automatic chk(input logic [3:0] got, input logic [3:0] exp);
		testsRun++;
		if (got !== exp) begin
			fails++;
			$display("unexpected t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic final_report();
		$display("checks %0d mismatches %0d", testsRun, fails);
		if (fails == 0 && testsRun > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : final_report
	// Hang guard, far above the expected run of some 140 cycles
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 1000) begin
			fails++;
			final_report();
		end
	end
	initial begin
		repeat (20) @(posedge ref_clk);
		reset_n <= 1'b1;
		// Ports differ within the middle two rows, so any crosstalk shows up
		foreach (rows[i]) begin
			portEnable <= rows[i][23:20];
			faultReq <= rows[i][19:16];
			repeat (20) @(posedge ref_clk);
			#1;
			chk(pOe, rows[i][15:12]);
			chk(pOut & pOe, 4'h0);
			chk(pPu, rows[i][11:8]);
			chk(ocAct, rows[i][7:4]);
			chk(pwrOn, rows[i][3:0]);
			$display("row %0d done", i);
		end
		// Sticky flags survive disable, then clear
		chk(ocLat, 4'h7);
		@(posedge ref_clk);
		ocClear <= 4'hF;
		@(posedge ref_clk);
		ocClear <= 4'h0;
		@(posedge ref_clk);
		#1;
		chk(ocLat, 4'h0);
		$display("clear test done");
		// Frozen clock enable holds the pins driven low
		@(posedge ref_clk);
		clkEn <= 1'b0;
		portEnable <= 4'hF;
		repeat (4) @(posedge ref_clk);
		#1;
		chk(pOe, 4'hF);
		@(posedge ref_clk);
		clkEn <= 1'b1;
		repeat (4) @(posedge ref_clk);
		#1;
		chk(pOe, 4'h0);
		$display("freeze test done");
		// Port 4 fault, then a clear while the fault is still active loses to it
		@(posedge ref_clk);
		faultReq <= 4'h8;
		repeat (20) @(posedge ref_clk);
		#1;
		chk(ocAct, 4'h8);
		chk(ocLat, 4'h8);
		@(posedge ref_clk);
		ocClear <= 4'h8;
		@(posedge ref_clk);
		ocClear <= 4'h0;
		@(posedge ref_clk);
		#1;
		chk(ocLat, 4'h8);
		$display("set wins test done");
		// Reset in mid-run drives all pins low and drops the flags
		@(posedge ref_clk);
		reset_n <= 1'b0;
		faultReq <= 4'h0;
		#1;
		chk(pOe, 4'hF);
		chk(pPu, 4'h0);
		chk(ocAct, 4'h0);
		chk(ocLat, 4'h0);
		repeat (3) @(posedge ref_clk);
		reset_n <= 1'b1;
		// First edge after release already takes the enables
		@(posedge ref_clk);
		#1;
		chk(pOe, 4'h0);
		chk(pPu, 4'hF);
		@(posedge ref_clk);
		#1;
		chk(ocAct, 4'h0);
		$display("hand tests done");
		final_report();
	end
endmodule : ppoc_pins_tb_top
